// file: design/pci_power_mgmt_capability.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE_01] Bit 19 reads 0: wake clock-independent.
// [RULE_02] Bits 18:16 read version code 010b.
// [RULE_03] Next-capability pointer reads 00h, list ends.
// [RULE_04] Capability identifier reads 01h.
// [RULE_05] Wake event sets status flag regardless of enable.
// [RULE_06] Writing one clears status; zero does nothing.
// [RULE_07] Status retained across resets only if d3cold.
// [RULE_08] Data-scale field reads 00b.
// [RULE_09] Data-select field writable, resets to 0000b.
// [RULE_10] Wake pin asserts only while enable set.
// [RULE_11] Enable retained across resets only if d3cold.
// [RULE_12] Power-state field reads and requests state, resets 00b.
// [RULE_13] Unsupported power-state writes discarded, bus completes.
// [RULE_14] D3cold support needs aux sense and stored bit.
// [RULE_15] Wake pin active while status and enable set.
module pci_power_mgmt_capability #(
  parameter logic [3:0] SUPPORTED_STATES = 4'hF
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire logic                          por_b,
  input  wire logic                          sw_reset,
  input  wire logic                          aux_power_sense,
  input  wire logic                          d3cold_cfg_bit,
  input  wire logic                          wake_event,
  input  wire pm_cap_pkg::cfg_req_type       cfg_req,
  output logic [pm_cap_pkg::DATA_W-1:0]      cfg_rdata,
  output logic                               cfg_rvalid,
  output logic                               wake_pin_out,
  output logic                               wake_pin_oe,
  output pm_cap_pkg::power_state_type        power_state_field
);

  // Byte-enable test, shared by both write lanes.
  function automatic logic lane_on(input logic [3:0] be, input int lane);
    lane_on = be[lane];
  endfunction : lane_on

  ////////////////////////////////////////////////////////////////////////////////
  // Reset tracking and strap capture.
  //
  // reset_hold is high for exactly the first edge after rst_b releases. That edge
  // is where the strap is sampled, and, when the strap reads zero, where the
  // retained bits are cleared so that they behave like ordinary reset fields.

  logic       reset_hold;
  logic       d3cold_wake_support;
  logic       strap_value;
  logic       soft_clear;

  assign strap_value = aux_power_sense & d3cold_cfg_bit; // see [RULE_14]

  // The strap is caught on the first edge after release; a flop under async reset
  // may only load a constant.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_hold <= 1'b1;
    end else begin
      reset_hold <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      d3cold_wake_support <= 1'b0;
    end else if (reset_hold) begin
      d3cold_wake_support <= strap_value; // see [RULE_14]
    end
  end

  // Without d3cold support the retained bits follow ordinary resets back to zero.
  // A software reset with support present leaves them alone.
  assign soft_clear = (reset_hold && !strap_value) || (sw_reset && !d3cold_wake_support); // see [RULE_07] see [RULE_11]

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode.
  //
  // A write lands in the same cycle that it is presented; there is no answer on the
  // bus for a write, so every field below is updated straight from the request.

  logic       ctrl_hit;
  logic       caps_hit;
  logic       wr_low;
  logic       wr_high;
  logic [1:0] wr_pstate;
  logic       pstate_ok;
  logic       wr_status_ones;
  logic       wr_enable_value;
  logic [3:0] wr_select;

  // Writes to the capability word decode to nothing: every bit there is read-only.
  assign ctrl_hit  = (cfg_req.addr == pm_cap_pkg::CTRL_OFFSET);
  assign caps_hit  = (cfg_req.addr == pm_cap_pkg::CAPS_OFFSET);
  assign wr_low    = cfg_req.wr && ctrl_hit && lane_on(cfg_req.be, pm_cap_pkg::LANE_LOW);
  assign wr_high   = cfg_req.wr && ctrl_hit && lane_on(cfg_req.be, pm_cap_pkg::LANE_HIGH);
  assign wr_pstate = cfg_req.wdata[pm_cap_pkg::PSTATE_LSB +: 2];
  // Codes outside SUPPORTED_STATES are dropped here, before they reach the state flops.
  assign pstate_ok = SUPPORTED_STATES[wr_pstate]; // see [RULE_13]

  assign wr_status_ones  = cfg_req.wdata[pm_cap_pkg::STATUS_BIT];
  assign wr_enable_value = cfg_req.wdata[pm_cap_pkg::ENABLE_BIT];
  assign wr_select       = cfg_req.wdata[pm_cap_pkg::SELECT_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields.
  //
  // Status and enable live in retained_bit so that only the power-up reset clears
  // them unconditionally; the strap decides whether lighter resets reach them too.
  // Select and power state are ordinary fields: rst_b or a software reset returns
  // them to their reset codes; por_b, the power-up reset, does not reach them.

  logic       wake_status_flag;
  logic       wake_enable_bit;
  logic [3:0] power_data_select;

  retained_bit u_status (
    .ref_clk    (ref_clk),
    .por_b      (por_b),
    .soft_clear (soft_clear),
    .hw_set     (wake_event),                                   // see [RULE_05]
    .sw_write   (wr_high),
    .sw_value   (wr_status_ones),
    .w1c_mode   (1'b1),                                         // see [RULE_06]
    .value      (wake_status_flag)
  );

  retained_bit u_enable (
    .ref_clk    (ref_clk),
    .por_b      (por_b),
    .soft_clear (soft_clear),
    .hw_set     (1'b0),
    .sw_write   (wr_high),
    .sw_value   (wr_enable_value),
    .w1c_mode   (1'b0),
    .value      (wake_enable_bit)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_data_select <= pm_cap_pkg::SELECT_RESET;
    end else if (sw_reset) begin
      power_data_select <= pm_cap_pkg::SELECT_RESET; // see [RULE_09]
    end else if (wr_high) begin
      power_data_select <= wr_select; // see [RULE_09]
    end
  end

  // An unsupported code still completes on the bus; only the state change is dropped.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state_field <= pm_cap_pkg::power_state_type'(pm_cap_pkg::PSTATE_RESET);
    end else if (sw_reset) begin
      power_state_field <= pm_cap_pkg::power_state_type'(pm_cap_pkg::PSTATE_RESET); // see [RULE_12]
    end else if (wr_low && pstate_ok) begin
      power_state_field <= pm_cap_pkg::power_state_type'(wr_pstate); // see [RULE_12] see [RULE_13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake pin, open drain: driven low only while asserted.
  //
  // The pin is never driven high; the board pull-up gives the idle level. Keeping
  // the enable purely combinational off two flops means the pin follows a clear
  // in the same cycle that the flag drops, with no extra latency.

  assign wake_pin_out = 1'b0;
  assign wake_pin_oe  = wake_status_flag && wake_enable_bit; // see [RULE_10] see [RULE_15]

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [pm_cap_pkg::DATA_W-1:0] caps_word;
  logic [pm_cap_pkg::DATA_W-1:0] ctrl_word;
  logic [pm_cap_pkg::DATA_W-1:0] read_word;

  // Unimplemented and reserved bits are forced to zero by starting from ZERO_WORD.
  always_comb begin
    caps_word = pm_cap_pkg::ZERO_WORD;
    caps_word[pm_cap_pkg::D3COLD_BIT]           = d3cold_wake_support;          // see [RULE_14]
    caps_word[pm_cap_pkg::CLK_DEP_BIT]          = pm_cap_pkg::CLK_DEP_VALUE;    // see [RULE_01]
    caps_word[pm_cap_pkg::VER_LSB +: 3]         = pm_cap_pkg::VER_VALUE;        // see [RULE_02]
    caps_word[pm_cap_pkg::NEXT_PTR_LSB +: 8]    = pm_cap_pkg::NEXT_PTR_VALUE;   // see [RULE_03]
    caps_word[pm_cap_pkg::CAP_ID_LSB +: 8]      = pm_cap_pkg::CAP_ID_VALUE;     // see [RULE_04]
  end

  always_comb begin
    ctrl_word = pm_cap_pkg::ZERO_WORD;
    ctrl_word[pm_cap_pkg::STATUS_BIT]           = wake_status_flag;
    ctrl_word[pm_cap_pkg::SCALE_LSB +: 2]       = pm_cap_pkg::SCALE_VALUE;      // see [RULE_08]
    ctrl_word[pm_cap_pkg::SELECT_LSB +: 4]      = power_data_select;
    ctrl_word[pm_cap_pkg::ENABLE_BIT]           = wake_enable_bit;
    ctrl_word[pm_cap_pkg::PSTATE_LSB +: 2]      = power_state_field;            // see [RULE_12]
  end

  // Any other address reads zero, like an unclaimed configuration dword.
  assign read_word = caps_hit ? caps_word :
                     ctrl_hit ? ctrl_word :
                                pm_cap_pkg::ZERO_WORD;

  // The answer is registered so that the read data is a clean flop output; the
  // host takes it one cycle after the request, while cfg_rvalid stands.
  logic                          next_rvalid;
  logic [pm_cap_pkg::DATA_W-1:0] next_rdata;

  assign next_rvalid = cfg_req.rd;
  assign next_rdata  = cfg_req.rd ? read_word : cfg_rdata;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= next_rvalid;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= pm_cap_pkg::ZERO_WORD;
    end else begin
      cfg_rdata <= next_rdata;
    end
  end

endmodule : pci_power_mgmt_capability
`default_nettype wire

// file: design/pm_cap_pkg.sv
package pm_cap_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;

  // Configuration-space offsets of the register pair.
  localparam logic [7:0]  CAPS_OFFSET       = 8'hC0;
  localparam logic [7:0]  CTRL_OFFSET       = 8'hC4;

  // Capability register fields and fixed values.
  localparam int          D3COLD_BIT        = 31;
  localparam int          CLK_DEP_BIT       = 19;
  localparam int          VER_LSB           = 16;
  localparam int          NEXT_PTR_LSB      = 8;
  localparam int          CAP_ID_LSB        = 0;
  localparam logic        CLK_DEP_VALUE     = 1'b0;
  localparam logic [2:0]  VER_VALUE         = 3'h2;
  localparam logic [7:0]  NEXT_PTR_VALUE    = 8'h00;
  localparam logic [7:0]  CAP_ID_VALUE      = 8'h01;

  // Control/status register fields.
  localparam int          STATUS_BIT        = 15;
  localparam int          SCALE_LSB         = 13;
  localparam int          SELECT_LSB        = 9;
  localparam int          ENABLE_BIT        = 8;
  localparam int          PSTATE_LSB        = 0;
  localparam logic [1:0]  SCALE_VALUE       = 2'h0;
  localparam logic [3:0]  SELECT_RESET      = 4'h0;
  localparam logic [1:0]  PSTATE_RESET      = 2'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;

  // Byte lanes that carry the writable control fields.
  localparam int          LANE_LOW          = 0;
  localparam int          LANE_HIGH         = 1;

  typedef enum logic [1:0] {
    STATE_D0,
    STATE_D1,
    STATE_D2,
    STATE_D3HOT
  } power_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [3:0]        be;
    logic [DATA_W-1:0] wdata;
  } cfg_req_type;

endpackage : pm_cap_pkg

// file: design/retained_bit.sv
`timescale 1ns/1ps
`default_nettype none

// One control bit that only the power-up reset clears asynchronously; lighter resets
// reach it through soft_clear so that a retained bit can ride them out.
module retained_bit (
  input  wire logic ref_clk,
  input  wire logic por_b,
  input  wire logic soft_clear,
  input  wire logic hw_set,
  input  wire logic sw_write,
  input  wire logic sw_value,
  input  wire logic w1c_mode,
  output logic      value
);

  logic next_value;

  // A hardware set beats a simultaneous software clear, so no event is lost.
  assign next_value = soft_clear ? 1'b0 :
                      hw_set     ? 1'b1 :
                      !sw_write  ? value :
                      w1c_mode   ? (value & ~sw_value) :
                                   sw_value;

  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      value <= 1'b0;
    end else begin
      value <= next_value;
    end
  end

endmodule : retained_bit
`default_nettype wire

// file: verif/cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  input  wire logic               ref_clk,
  input  wire logic [31:0]        cfg_rdata,
  input  wire logic               cfg_rvalid,
  output var pm_cap_pkg::cfg_req_type cfg_req
);
  initial cfg_req = '0;
  // Released address, byte-enable and data lines show the inverse of their last value so stale data is never mistaken for live data; rd and wr drop low.
  task automatic drop();
    @(posedge ref_clk) #1;
    cfg_req = ~cfg_req;
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
  endtask : drop
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge ref_clk) #1;
    cfg_req = '{a, 1'b0, 1'b1, b, v};
    drop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk) #1;
    cfg_req = '{a, 1'b1, 1'b0, 4'h0, 32'h0000_0000};
    drop();
    v = cfg_rvalid ? cfg_rdata : 32'hxxxx_xxxx;
  endtask : rd
endmodule : cfg_host
`default_nettype wire

// file: verif/pm_cap_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pm_cap_chk #(
  parameter logic [3:0] SUPPORTED_STATES = 4'hF
) (
  input wire logic                        ref_clk,
  input wire logic                        rst_b,
  input wire logic                        wake_event,
  input wire pm_cap_pkg::cfg_req_type     cfg_req,
  input wire logic [31:0]                 cfg_rdata,
  input wire logic                        cfg_rvalid,
  input wire logic                        wake_pin_oe,
  input wire pm_cap_pkg::power_state_type power_state_field
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_cap = cfg_req.rd && cfg_req.addr == pm_cap_pkg::CAPS_OFFSET;
  wire logic rd_ctl = cfg_req.rd && cfg_req.addr == pm_cap_pkg::CTRL_OFFSET;
  wire logic wr_ctl = cfg_req.wr && cfg_req.addr == pm_cap_pkg::CTRL_OFFSET;
  wire logic ok_st  = SUPPORTED_STATES[cfg_req.wdata[1:0]];
  AST_RVALID: assert property (cfg_rvalid == $past(cfg_req.rd))
    else $error("read answer not one cycle after request");
  AST_CAPS: assert property (rd_cap |=> cfg_rdata[30:0] == 31'h0002_0001)
    else $error("capability header wrong");
  AST_FIXED: assert property (rd_ctl |=> cfg_rdata[31:16] == '0 && cfg_rdata[14:13] == '0 && cfg_rdata[7:2] == '0)
    else $error("fixed control bits not zero");
  AST_STATE_RD: assert property (rd_ctl |=> cfg_rdata[1:0] == power_state_field)
    else $error("state read differs from state");
  AST_STATE_WR: assert property (wr_ctl && cfg_req.be[0] && ok_st |=> power_state_field == $past(cfg_req.wdata[1:0]))
    else $error("supported state not taken");
  AST_DISCARD: assert property (wr_ctl && cfg_req.be[0] && !ok_st |=> $stable(power_state_field))
    else $error("unsupported state taken");
  AST_PIN: assert property (rd_ctl && !wake_event |=> wake_pin_oe == (cfg_rdata[15] && cfg_rdata[8]))
    else $error("wake pin not status and enable");
  AST_W1C: assert property (wr_ctl && cfg_req.be[1] && cfg_req.wdata[15] && !wake_event |=> !wake_pin_oe)
    else $error("wake pin held after clear");
endmodule : pm_cap_chk
////////////////////////////////////////////////////////////////////////////////
bind pci_power_mgmt_capability pm_cap_chk #(.SUPPORTED_STATES(SUPPORTED_STATES)) i_chk (.ref_clk(ref_clk),
  .rst_b(rst_b), .wake_event(wake_event), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .wake_pin_oe(wake_pin_oe), .power_state_field(power_state_field));
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        por_b = 1'b0;
  logic        sw_reset = 1'b0;
  logic        aux = 1'b1;
  logic        wake_event = 1'b0;
  logic [31:0] rdata;
  logic        rvalid;
  logic        pin_out;
  logic        pin_oe;
  logic [31:0] d;
  int          fails = 0;
  int          tests_run = 0;
  pm_cap_pkg::cfg_req_type     req;
  pm_cap_pkg::power_state_type st;
  // Open-drain wake line with a pull-up.
  wire logic   pme_b = pin_oe ? pin_out : 1'b1;
  always #20 ref_clk = ~ref_clk;
  pci_power_mgmt_capability #(.SUPPORTED_STATES(4'h7)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .por_b(por_b),
    .sw_reset(sw_reset), .aux_power_sense(aux), .d3cold_cfg_bit(1'b1), .wake_event(wake_event), .cfg_req(req),
    .cfg_rdata(rdata), .cfg_rvalid(rvalid), .wake_pin_out(pin_out), .wake_pin_oe(pin_oe), .power_state_field(st));
  cfg_host i_host (.ref_clk(ref_clk), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .cfg_req(req));
  task automatic pulse(ref logic s);
    @(posedge ref_clk) #1 s = ~s;
    @(posedge ref_clk) #1 s = ~s;
  endtask : pulse
  task automatic t_caps();
    i_host.rd(8'hC0, d);
    `CHK(d[31], 1'b1)
    `CHK(d[19:16], 4'h2)
    `CHK(d[15:0], 16'h0001)
    i_host.wr(8'hC0, 4'hF, 32'hFFFF_FFFF);
    i_host.rd(8'hC0, d);
    `CHK(d, 32'h8002_0001)
    $display("caps done");
  endtask : t_caps
  task automatic t_ctrl();
    i_host.rd(8'hC4, d);
    `CHK(d, 32'h0000_0000)
    i_host.wr(8'hC4, 4'h3, 32'hFFFF_7EFE);
    i_host.rd(8'hC4, d);
    `CHK(d, 32'h0000_1E02)
    for (int s = 0; s < 4; s++) begin
      i_host.wr(8'hC4, 4'h1, 32'(s));
      `CHK(st, s == 3 ? 2'h2 : 2'(s))
    end
    $display("ctrl done");
  endtask : t_ctrl
  task automatic t_wake();
    i_host.wr(8'hC4, 4'h2, 32'h0000_0000);
    pulse(wake_event);
    `CHK(pme_b, 1'b1)
    i_host.rd(8'hC4, d);
    `CHK(d[15:8], 8'h80)
    i_host.wr(8'hC4, 4'h2, 32'h0000_0100);
    `CHK(pme_b, 1'b0)
    i_host.wr(8'hC4, 4'h2, 32'h0000_8100);
    `CHK(pme_b, 1'b1)
    $display("wake done");
  endtask : t_wake
  task automatic t_keep();
    pulse(wake_event);
    pulse(sw_reset);
    pulse(rst_b);
    @(posedge ref_clk) #1;
    `CHK(pme_b, 1'b0)
    i_host.rd(8'hC4, d);
    `CHK(d, 32'h0000_8100)
    aux = 1'b0;
    pulse(rst_b);
    @(posedge ref_clk) #1;
    `CHK(pme_b, 1'b1)
    i_host.rd(8'hC0, d);
    `CHK(d, 32'h0002_0001)
    $display("keep done");
  endtask : t_keep
  task automatic complete_run();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #(40 * 5000);
    fails++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    por_b = 1'b1;
    t_caps();
    t_ctrl();
    t_wake();
    t_keep();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
